// ===== rtl/simd_multiply_accumulate.sv
// Behaviour
// - each 64-bit operand is two independent 32-bit lanes that get the same operation; guarded and full forms use the low lane only.
// - every general register is 64 bits wide and holds both lanes.
// - a private accumulator keeps results so accumulate ops chain without a general register.
// - halfword forms multiply the odd or even 16-bit halves into 32 bits when plain and into 64 bits when guarded.
// - plain word forms keep the upper or lower 32 product bits; guarded forms keep 64 bits, the upper one shifted down 32; full form keeps 64.
// - signed and unsigned integer and signed fractional types, each saturating or modulo.
// - there is no unsigned fractional type since it equals unsigned integer.
// - lower-word forms with either signed fractional type are refused.
// - accumulate writes, adds or subtracts (whole or per word) and the result lands in it.
// - floating-point operands are read from the same 64-bit general registers.
`timescale 1ns/1ps
`default_nettype none
module simd_multiply_accumulate (
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire logic                             issue_valid,
  input  wire simd_mac_pkg::mul_form_t          issue_form,
  input  wire simd_mac_pkg::data_type_t         issue_dtype,
  input  wire simd_mac_pkg::acc_mode_t          issue_acc,
  input  wire logic [simd_mac_pkg::IDX_W-1:0]   issue_ra,
  input  wire logic [simd_mac_pkg::IDX_W-1:0]   issue_rb,
  input  wire logic [simd_mac_pkg::IDX_W-1:0]   issue_rd,
  input  wire logic                             gpr_wr_en,
  input  wire logic [simd_mac_pkg::IDX_W-1:0]   gpr_wr_idx,
  input  wire logic [simd_mac_pkg::GPR_W-1:0]   gpr_wr_data,
  input  wire logic [simd_mac_pkg::IDX_W-1:0]   fp_ra,
  input  wire logic [simd_mac_pkg::IDX_W-1:0]   fp_rb,
  output logic                                  result_valid,
  output logic                                  result_illegal,
  output logic                                  result_sat,
  output logic [simd_mac_pkg::GPR_W-1:0]        result_data,
  output logic [simd_mac_pkg::GPR_W-1:0]        mac_accumulator,
  output logic [simd_mac_pkg::GPR_W-1:0]        fp_opa,
  output logic [simd_mac_pkg::GPR_W-1:0]        fp_opb
);

  // returns {overflow, value}; clamps only when saturating
  function automatic logic [64:0] narrow(input logic signed [67:0] v,
                                         input logic [6:0] w,
                                         input logic sgn,
                                         input logic sat);
    logic signed [67:0] maxv;
    logic signed [67:0] minv;
    maxv = sgn ? (68'sd1 <<< (w - 7'd1)) - 68'sd1 : (68'sd1 <<< w) - 68'sd1;
    minv = sgn ? -(68'sd1 <<< (w - 7'd1)) : 68'sd0;
    if (sat && v > maxv)
      narrow = {1'b1, maxv[63:0]};
    else if (sat && v < minv)
      narrow = {1'b1, minv[63:0]};
    else
      narrow = {1'b0, v[63:0]};
  endfunction

  gpr_port_if io ();

  gpr_file u_gpr (
    .clk  (clk),
    .nrst (nrst),
    .io   (io.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // issue decode and stage one

  logic                      s1_valid_r,   s1_valid_nxt;
  logic                      s1_illegal_r, s1_illegal_nxt;
  simd_mac_pkg::mul_form_t   s1_form_r,    s1_form_nxt;
  simd_mac_pkg::data_type_t  s1_dtype_r,   s1_dtype_nxt;
  simd_mac_pkg::acc_mode_t   s1_acc_r,     s1_acc_nxt;
  logic [simd_mac_pkg::IDX_W-1:0] s1_rd_r, s1_rd_nxt;

  always_comb
  begin
    s1_valid_nxt = issue_valid;
    s1_form_nxt  = issue_form;
    s1_dtype_nxt = issue_dtype;
    s1_acc_nxt   = issue_acc;
    s1_rd_nxt    = issue_rd;
    s1_illegal_nxt = 1'b0;
    // no unsigned fractional code exists; unknown codes are refused too
    if (issue_dtype > simd_mac_pkg::dt_signed_mod_frac ||
        issue_form > simd_mac_pkg::word_full_mul ||
        issue_acc > simd_mac_pkg::acc_sub_word)
      s1_illegal_nxt = 1'b1;
    if ((issue_form == simd_mac_pkg::word_lower_mul ||
         issue_form == simd_mac_pkg::word_lower_guard_mul) &&
        (issue_dtype == simd_mac_pkg::dt_signed_sat_frac ||
         issue_dtype == simd_mac_pkg::dt_signed_mod_frac))
      s1_illegal_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_valid_r   <= 1'b0;
      s1_illegal_r <= 1'b0;
      s1_form_r    <= simd_mac_pkg::half_odd_mul;
      s1_dtype_r   <= simd_mac_pkg::dt_unsigned_sat_int;
      s1_acc_r     <= simd_mac_pkg::acc_none;
      s1_rd_r      <= '0;
    end
    else
    begin
      s1_valid_r   <= s1_valid_nxt;
      s1_illegal_r <= s1_illegal_nxt;
      s1_form_r    <= s1_form_nxt;
      s1_dtype_r   <= s1_dtype_nxt;
      s1_acc_r     <= s1_acc_nxt;
      s1_rd_r      <= s1_rd_nxt;
    end
  end

  // floating-point unit reads the very same register file
  always_comb
  begin
    io.rd_idx[simd_mac_pkg::RP_A]  = issue_ra;
    io.rd_idx[simd_mac_pkg::RP_B]  = issue_rb;
    io.rd_idx[simd_mac_pkg::RP_FA] = fp_ra;
    io.rd_idx[simd_mac_pkg::RP_FB] = fp_rb;
  end

  logic [simd_mac_pkg::GPR_W-1:0] op_a;
  logic [simd_mac_pkg::GPR_W-1:0] op_b;
  assign op_a = io.rd_data[simd_mac_pkg::RP_A];
  assign op_b = io.rd_data[simd_mac_pkg::RP_B];

  ////////////////////////////////////////////////////////////////////////////
  // lane multipliers

  logic sgn, frac, sat, half, odd, high, guard, full;
  always_comb
  begin
    sgn  = s1_dtype_r >= simd_mac_pkg::dt_signed_sat_int;
    frac = s1_dtype_r == simd_mac_pkg::dt_signed_sat_frac ||
           s1_dtype_r == simd_mac_pkg::dt_signed_mod_frac;
    sat  = s1_dtype_r == simd_mac_pkg::dt_unsigned_sat_int ||
           s1_dtype_r == simd_mac_pkg::dt_signed_sat_int ||
           s1_dtype_r == simd_mac_pkg::dt_signed_sat_frac;
    half  = s1_form_r <= simd_mac_pkg::half_even_guard_mul;
    odd   = s1_form_r == simd_mac_pkg::half_odd_mul ||
            s1_form_r == simd_mac_pkg::half_odd_guard_mul;
    high  = s1_form_r == simd_mac_pkg::word_upper_mul ||
            s1_form_r == simd_mac_pkg::word_upper_guard_mul;
    guard = s1_form_r == simd_mac_pkg::half_odd_guard_mul ||
            s1_form_r == simd_mac_pkg::half_even_guard_mul ||
            s1_form_r == simd_mac_pkg::word_upper_guard_mul ||
            s1_form_r == simd_mac_pkg::word_lower_guard_mul;
    full  = s1_form_r == simd_mac_pkg::word_full_mul;
  end

  logic signed [simd_mac_pkg::WIDE_W-1:0] lane_wide [simd_mac_pkg::LANES];
  logic [simd_mac_pkg::LANE_W-1:0]        lane_res  [simd_mac_pkg::LANES];
  logic [simd_mac_pkg::LANES-1:0]         lane_sat;
  logic [simd_mac_pkg::GPR_W-1:0]         vec_res;
  logic [simd_mac_pkg::GPR_W-1:0]         word_acc;
  logic [simd_mac_pkg::LANES-1:0]         word_sat;
  logic [simd_mac_pkg::GPR_W-1:0]         mac_acc_r;

  for (genvar g = 0; g < simd_mac_pkg::LANES; g++)
  begin : g_lane
    logic [simd_mac_pkg::LANE_W-1:0]  a_w, b_w;
    logic [simd_mac_pkg::HALF_W-1:0]  a_h, b_h;
    logic signed [32:0]               a_x, b_x;
    logic signed [65:0]               prod;
    logic signed [67:0]               wide, pick, acc_x, res_x, sumw;
    logic [64:0]                      nr, nw;
    always_comb
    begin
      a_w = op_a[g*simd_mac_pkg::LANE_W +: simd_mac_pkg::LANE_W];
      b_w = op_b[g*simd_mac_pkg::LANE_W +: simd_mac_pkg::LANE_W];
      a_h = odd ? a_w[15:0] : a_w[31:16];
      b_h = odd ? b_w[15:0] : b_w[31:16];
      if (half)
      begin
        a_x = {{17{sgn & a_h[15]}}, a_h};
        b_x = {{17{sgn & b_h[15]}}, b_h};
      end
      else
      begin
        a_x = {sgn & a_w[31], a_w};
        b_x = {sgn & b_w[31], b_w};
      end
      prod = a_x * b_x;
      // fractional products drop the duplicated sign bit
      wide = frac ? {prod[65], prod, 1'b0} : {{2{prod[65]}}, prod};
      pick = high ? (wide >>> simd_mac_pkg::HIGH_SHIFT) : wide;
      nr   = narrow(pick, simd_mac_pkg::NARROW_LANE, sgn, sat);
    end
    // own process, so the lane product never waits on vec_res
    always_comb
    begin
      acc_x = {{36{sgn & mac_acc_r[g*32+31]}}, mac_acc_r[g*32 +: 32]};
      res_x = {{36{sgn & vec_res[g*32+31]}}, vec_res[g*32 +: 32]};
      sumw = (s1_acc_r == simd_mac_pkg::acc_add_word) ? acc_x + res_x : acc_x - res_x;
      nw   = narrow(sumw, simd_mac_pkg::NARROW_LANE, sgn, sat);
    end
    assign lane_wide[g] = pick;
    assign lane_res[g]  = nr[31:0];
    assign lane_sat[g]  = nr[64];
    assign word_acc[g*32 +: 32] = nw[31:0];
    assign word_sat[g]  = nw[64];
  end

  ////////////////////////////////////////////////////////////////////////////
  // result assembly and accumulate

  logic [64:0]              nr64;
  logic signed [67:0]       acc_ext, res_ext, sum64;
  logic [64:0]              ns64;
  logic                     mul_sat;
  logic [63:0]              final_val;
  logic                     final_sat;

  always_comb
  begin
    nr64 = narrow(lane_wide[0], simd_mac_pkg::NARROW_FULL, sgn, sat);
    // guarded and full-word forms keep a 64-bit scalar from the low lane
    if (full || guard)
    begin
      vec_res = nr64[63:0];
      mul_sat = nr64[64];
    end
    else
    begin
      vec_res = {lane_res[1], lane_res[0]};
      mul_sat = |lane_sat;
    end
  end

  always_comb
  begin
    acc_ext = {{4{sgn & mac_acc_r[63]}}, mac_acc_r};
    res_ext = {{4{sgn & vec_res[63]}}, vec_res};
    sum64 = (s1_acc_r == simd_mac_pkg::acc_add) ? acc_ext + res_ext : acc_ext - res_ext;
    ns64  = narrow(sum64, simd_mac_pkg::NARROW_FULL, sgn, sat);
    final_val = vec_res;
    final_sat = mul_sat;
    unique case (s1_acc_r)
      simd_mac_pkg::acc_add, simd_mac_pkg::acc_sub:
      begin
        final_val = ns64[63:0];
        final_sat = mul_sat | ns64[64];
      end
      simd_mac_pkg::acc_add_word, simd_mac_pkg::acc_sub_word:
      begin
        final_val = word_acc;
        final_sat = mul_sat | (|word_sat);
      end
      default:
      begin
        final_val = vec_res;
        final_sat = mul_sat;
      end
    endcase
  end

  logic commit;
  assign commit = s1_valid_r && !s1_illegal_r;

  always_comb
  begin
    io.wr0_en   = commit;
    io.wr0_idx  = s1_rd_r;
    io.wr0_data = final_val;
    io.wr1_en   = gpr_wr_en;
    io.wr1_idx  = gpr_wr_idx;
    io.wr1_data = gpr_wr_data;
  end

  logic        res_valid_r, res_valid_nxt;
  logic        res_illegal_r, res_illegal_nxt;
  logic        res_sat_r, res_sat_nxt;
  logic [63:0] res_data_r, res_data_nxt;
  logic [63:0] mac_acc_nxt;

  always_comb
  begin
    res_valid_nxt   = s1_valid_r;
    res_illegal_nxt = s1_valid_r && s1_illegal_r;
    res_sat_nxt     = commit && final_sat;
    res_data_nxt    = commit ? final_val : res_data_r;
    mac_acc_nxt     = mac_acc_r;
    // chaining reads mac_acc_r directly, never a general register
    if (commit && s1_acc_r != simd_mac_pkg::acc_none)
      mac_acc_nxt = final_val;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      res_valid_r   <= 1'b0;
      res_illegal_r <= 1'b0;
      res_sat_r     <= 1'b0;
      res_data_r    <= simd_mac_pkg::RES_RESET;
      mac_acc_r     <= simd_mac_pkg::ACC_RESET;
    end
    else
    begin
      res_valid_r   <= res_valid_nxt;
      res_illegal_r <= res_illegal_nxt;
      res_sat_r     <= res_sat_nxt;
      res_data_r    <= res_data_nxt;
      mac_acc_r     <= mac_acc_nxt;
    end
  end

  assign result_valid    = res_valid_r;
  assign result_illegal  = res_illegal_r;
  assign result_sat      = res_sat_r;
  assign result_data     = res_data_r;
  assign mac_accumulator = mac_acc_r;
  assign fp_opa          = io.rd_data[simd_mac_pkg::RP_FA];
  assign fp_opb          = io.rd_data[simd_mac_pkg::RP_FB];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic s1_plain;
  assign s1_plain = s1_valid_r && s1_acc_r == simd_mac_pkg::acc_none;

  chk_issue_latency: assert property (
    issue_valid |-> ##2 result_valid)
    else $error("result did not follow issue by two cycles");

  chk_lowfrac_refused: assert property (
    issue_valid && issue_form == simd_mac_pkg::word_lower_mul &&
    issue_dtype == simd_mac_pkg::dt_signed_mod_frac |-> ##2 (result_illegal && !result_sat))
    else $error("lower word fractional op was not refused");

  chk_acc_quiet: assert property (
    !s1_valid_r |=> $stable(mac_accumulator))
    else $error("accumulator changed without an op");

  chk_acc_receives: assert property (
    commit && s1_acc_r != simd_mac_pkg::acc_none |=> mac_accumulator == result_data)
    else $error("accumulator does not hold the result");

  chk_half_odd_umi: assert property (
    s1_plain && s1_form_r == simd_mac_pkg::half_odd_mul &&
    s1_dtype_r == simd_mac_pkg::dt_unsigned_mod_int
    |=> result_data == {32'($past(op_a[47:32])) * 32'($past(op_b[47:32])),
                        32'($past(op_a[15:0])) * 32'($past(op_b[15:0]))})
    else $error("odd halfword unsigned product wrong");

  chk_word_lower_mod: assert property (
    s1_plain && s1_form_r == simd_mac_pkg::word_lower_mul &&
    s1_dtype_r == simd_mac_pkg::dt_signed_mod_int
    |=> result_data[31:0] == 32'($past(op_a[31:0]) * $past(op_b[31:0])))
    else $error("lower word modulo product wrong");

  chk_frac_clamp: assert property (
    s1_plain && s1_form_r == simd_mac_pkg::half_odd_mul &&
    s1_dtype_r == simd_mac_pkg::dt_signed_sat_frac &&
    op_a[15:0] == 16'h8000 && op_b[15:0] == 16'h8000
    |=> result_data[31:0] == 32'h7FFF_FFFF && result_sat)
    else $error("fractional overflow not clamped");

  chk_wb_bypass: assert property (
    io.wr0_en && issue_ra == io.wr0_idx |=> op_a == $past(io.wr0_data))
    else $error("written 64-bit register not read back whole");

  chk_fp_shared: assert property (
    gpr_wr_en && fp_ra == gpr_wr_idx && !(io.wr0_en && io.wr0_idx == gpr_wr_idx)
    |=> fp_opa == $past(gpr_wr_data))
    else $error("floating operand not from shared register file");

  cov_chain: cover property (commit && s1_acc_r == simd_mac_pkg::acc_add ##1
                             commit && s1_acc_r == simd_mac_pkg::acc_add);
  cov_word_sub: cover property (commit && s1_acc_r == simd_mac_pkg::acc_sub_word);
  cov_sat: cover property (result_sat);
  cov_illegal: cover property (result_illegal);

endmodule
`default_nettype wire

// ===== rtl/simd_mac_pkg.sv
`default_nettype none
package simd_mac_pkg;

  localparam int GPR_W    = 64;
  localparam int LANE_W   = 32;
  localparam int HALF_W   = 16;
  localparam int LANES    = 2;
  localparam int GPR_CNT  = 32;
  localparam int IDX_W    = 5;
  localparam int RD_PORTS = 4;
  localparam int WIDE_W   = 68;

  // read port assignment on the shared register file
  localparam int RP_A  = 0;
  localparam int RP_B  = 1;
  localparam int RP_FA = 2;
  localparam int RP_FB = 3;

  localparam logic [63:0] ACC_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RES_RESET = 64'h0000_0000_0000_0000;
  localparam logic [6:0]  NARROW_LANE = 7'h20;
  localparam logic [6:0]  NARROW_FULL = 7'h40;
  localparam int          HIGH_SHIFT  = 32;
  localparam int          ISSUE_TO_RESULT = 2;

  typedef enum logic [3:0] {
    half_odd_mul        = 4'h0,
    half_even_mul       = 4'h1,
    half_odd_guard_mul  = 4'h2,
    half_even_guard_mul = 4'h3,
    word_upper_mul      = 4'h4,
    word_lower_mul      = 4'h5,
    word_upper_guard_mul = 4'h6,
    word_lower_guard_mul = 4'h7,
    word_full_mul       = 4'h8
  } mul_form_t;

  typedef enum logic [2:0] {
    dt_unsigned_sat_int = 3'h0,
    dt_unsigned_mod_int = 3'h1,
    dt_signed_sat_int   = 3'h2,
    dt_signed_sat_frac  = 3'h3,
    dt_signed_mod_int   = 3'h4,
    dt_signed_mod_frac  = 3'h5
  } data_type_t;

  typedef enum logic [2:0] {
    acc_none     = 3'h0,
    acc_write    = 3'h1,
    acc_add      = 3'h2,
    acc_sub      = 3'h3,
    acc_add_word = 3'h4,
    acc_sub_word = 3'h5
  } acc_mode_t;

endpackage
`default_nettype wire

// ===== rtl/gpr_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gpr_port_if;
  logic [simd_mac_pkg::IDX_W-1:0] rd_idx  [simd_mac_pkg::RD_PORTS];
  logic [simd_mac_pkg::GPR_W-1:0] rd_data [simd_mac_pkg::RD_PORTS];
  logic                           wr0_en;
  logic [simd_mac_pkg::IDX_W-1:0] wr0_idx;
  logic [simd_mac_pkg::GPR_W-1:0] wr0_data;
  logic                           wr1_en;
  logic [simd_mac_pkg::IDX_W-1:0] wr1_idx;
  logic [simd_mac_pkg::GPR_W-1:0] wr1_data;

  modport user  (output rd_idx, wr0_en, wr0_idx, wr0_data, wr1_en, wr1_idx, wr1_data,
                 input rd_data);
  modport store (input rd_idx, wr0_en, wr0_idx, wr0_data, wr1_en, wr1_idx, wr1_data,
                 output rd_data);
endinterface
`default_nettype wire

// ===== rtl/gpr_file.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_file (
  input  wire logic clk,
  input  wire logic nrst,
  gpr_port_if.store io
);

  logic [simd_mac_pkg::GPR_W-1:0] mem [simd_mac_pkg::GPR_CNT];
  logic [simd_mac_pkg::GPR_W-1:0] rd_nxt [simd_mac_pkg::RD_PORTS];
  logic [simd_mac_pkg::GPR_W-1:0] rd_r   [simd_mac_pkg::RD_PORTS];

  // write-first bypass so a back-to-back dependent op sees the fresh value;
  // the datapath port wins when both writers hit one entry
  always_comb
  begin
    for (int p = 0; p < simd_mac_pkg::RD_PORTS; p++)
    begin
      rd_nxt[p] = mem[io.rd_idx[p]];
      if (io.wr1_en && io.wr1_idx == io.rd_idx[p])
        rd_nxt[p] = io.wr1_data;
      if (io.wr0_en && io.wr0_idx == io.rd_idx[p])
        rd_nxt[p] = io.wr0_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (io.wr1_en && !(io.wr0_en && io.wr0_idx == io.wr1_idx))
      mem[io.wr1_idx] <= io.wr1_data;
    if (io.wr0_en)
      mem[io.wr0_idx] <= io.wr0_data;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int p = 0; p < simd_mac_pkg::RD_PORTS; p++)
        rd_r[p] <= simd_mac_pkg::RES_RESET;
    end
    else
    begin
      for (int p = 0; p < simd_mac_pkg::RD_PORTS; p++)
        rd_r[p] <= rd_nxt[p];
    end
  end

  assign io.rd_data = rd_r;

endmodule
`default_nettype wire

// ===== verification/gpr_shadow.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_shadow (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [63:0] wr_data
);
  // core-side copy of what was loaded; only external writes land here,
  // so operand registers must never be a datapath destination
  logic [63:0] mem [32];

  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end
endmodule
`default_nettype wire

// ===== verification/simd_multiply_accumulate_tb.sv
`timescale 1ns/1ps
`default_nettype none
module simd_multiply_accumulate_tb;
  typedef struct packed {
    logic        ill;
    logic        sat;
    logic [63:0] data;
    logic [63:0] acc;
  } exp_t;

  logic                      clk;
  logic                      nrst;
  logic                      issue_valid;
  simd_mac_pkg::mul_form_t   issue_form;
  simd_mac_pkg::data_type_t  issue_dtype;
  simd_mac_pkg::acc_mode_t   issue_acc;
  logic [4:0]                issue_ra;
  logic [4:0]                issue_rb;
  logic                      gpr_wr_en;
  logic [4:0]                gpr_wr_idx;
  logic [63:0]               gpr_wr_data;
  logic [4:0]                fp_ra;
  logic [4:0]                fp_rb;
  logic                      result_valid;
  logic                      result_illegal;
  logic                      result_sat;
  logic [63:0]               result_data;
  logic [63:0]               mac_accumulator;
  logic [63:0]               fp_opa;
  logic [63:0]               fp_opb;
  exp_t                      q[$];
  logic [63:0]               acc_e;
  logic [63:0]               last_d;
  int                        num_errors;
  int                        checks;
  int                        cyc;
  int                        seed;

  simd_multiply_accumulate u_dut (
    .clk(clk), .nrst(nrst), .issue_valid(issue_valid), .issue_form(issue_form),
    .issue_dtype(issue_dtype), .issue_acc(issue_acc), .issue_ra(issue_ra),
    .issue_rb(issue_rb), .issue_rd(5'h1f), .gpr_wr_en(gpr_wr_en),
    .gpr_wr_idx(gpr_wr_idx), .gpr_wr_data(gpr_wr_data), .fp_ra(fp_ra), .fp_rb(fp_rb),
    .result_valid(result_valid), .result_illegal(result_illegal),
    .result_sat(result_sat), .result_data(result_data),
    .mac_accumulator(mac_accumulator), .fp_opa(fp_opa), .fp_opb(fp_opb)
  );

  gpr_shadow u_core (.clk(clk), .wr_en(gpr_wr_en), .wr_idx(gpr_wr_idx),
                     .wr_data(gpr_wr_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp64(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // lane product for odd/even halfword and upper/lower word integer forms
  function automatic logic [31:0] lane(input logic [3:0] f, input logic s,
                                       input logic [31:0] a, input logic [31:0] b);
    logic [15:0] ha;
    logic [15:0] hb;
    logic [63:0] x;
    logic [63:0] y;
    logic [63:0] p;
    ha = f[0] ? a[31:16] : a[15:0];
    hb = f[0] ? b[31:16] : b[15:0];
    x = (f < 4'h4) ? {{48{s & ha[15]}}, ha} : {{32{s & a[31]}}, a};
    y = (f < 4'h4) ? {{48{s & hb[15]}}, hb} : {{32{s & b[31]}}, b};
    p = x * y;
    return (f == 4'h4) ? p[63:32] : p[31:0];
  endfunction

  task automatic load(input logic [4:0] i, input logic [63:0] d);
    @(negedge clk);
    gpr_wr_en = 1'b1;
    gpr_wr_idx = i;
    gpr_wr_data = d;
    fp_ra = i;
    fp_rb = i;
    @(negedge clk);
    gpr_wr_en = 1'b0;
    cmp64(fp_opa, d);
    cmp64(fp_opb, d);
  endtask

  // one issue per falling edge, so back-to-back calls give back-to-back ops
  task automatic issue(input logic [3:0] f, input logic [2:0] t, input logic [2:0] m,
                       input logic [4:0] a, input logic [4:0] b, input logic ill,
                       input logic sat, input logic [63:0] d);
    @(negedge clk);
    issue_valid = 1'b1;
    issue_form = simd_mac_pkg::mul_form_t'(f);
    issue_dtype = simd_mac_pkg::data_type_t'(t);
    issue_acc = simd_mac_pkg::acc_mode_t'(m);
    issue_ra = a;
    issue_rb = b;
    if (!ill)
      last_d = d;
    q.push_back('{ill, sat, last_d, acc_e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      num_errors++;
      final_report();
    end
  end

  always @(negedge clk)
  begin
    if (result_valid === 1'b1)
    begin
      if (q.size() == 0)
        cmp1(1'b1, 1'b0);
      else
      begin
        cmp1(result_illegal, q[0].ill);
        cmp1(result_sat, q[0].sat);
        cmp64(result_data, q[0].data);
        cmp64(mac_accumulator, q[0].acc);
        void'(q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [9:0]  bad [7];
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] p;
    logic [3:0]  f;
    // refused combinations packed as form, type, accumulate mode
    bad = '{10'h158, 10'h168, 10'h1d9, 10'h1e8, 10'h240, 10'h030, 10'h006};
    seed = 20;
    nrst = 1'b0;
    issue_valid = 1'b0;
    issue_form = simd_mac_pkg::half_odd_mul;
    issue_dtype = simd_mac_pkg::dt_unsigned_mod_int;
    issue_acc = simd_mac_pkg::acc_none;
    issue_ra = 5'h00;
    issue_rb = 5'h00;
    gpr_wr_en = 1'b0;
    gpr_wr_idx = 5'h00;
    gpr_wr_data = 64'h0000_0000_0000_0000;
    fp_ra = 5'h00;
    fp_rb = 5'h00;
    acc_e = simd_mac_pkg::ACC_RESET;
    last_d = simd_mac_pkg::RES_RESET;
    repeat (16) @(posedge clk);
    @(negedge clk);
    cmp64(result_data, 64'h0000_0000_0000_0000);
    cmp64(mac_accumulator, 64'h0000_0000_0000_0000);
    nrst = 1'b1;
    for (int i = 1; i < 5; i++)
      load(i[4:0], {$random(seed), $random(seed)});
    a = u_core.mem[1];
    b = u_core.mem[2];
    for (int i = 0; i < 8; i++)
    begin
      f = {1'b0, i[1], 1'b0, i[0]};
      issue(f, i[2] ? 3'h4 : 3'h1, 3'h0, 5'h01, 5'h02, 1'b0, 1'b0,
            {lane(f, i[2], a[63:32], b[63:32]), lane(f, i[2], a[31:0], b[31:0])});
    end
    p = {{32{a[31]}}, a[31:0]} * {{32{b[31]}}, b[31:0]};
    acc_e = p;
    issue(4'h8, 3'h4, 3'h1, 5'h01, 5'h02, 1'b0, 1'b0, acc_e);
    acc_e = acc_e + p;
    issue(4'h8, 3'h4, 3'h2, 5'h01, 5'h02, 1'b0, 1'b0, acc_e);
    acc_e = acc_e - p;
    issue(4'h8, 3'h4, 3'h3, 5'h01, 5'h02, 1'b0, 1'b0, acc_e);
    a = u_core.mem[3];
    b = u_core.mem[4];
    p = {lane(4'h0, 1'b0, a[63:32], b[63:32]), lane(4'h0, 1'b0, a[31:0], b[31:0])};
    acc_e = {acc_e[63:32] + p[63:32], acc_e[31:0] + p[31:0]};
    issue(4'h0, 3'h1, 3'h4, 5'h03, 5'h04, 1'b0, 1'b0, acc_e);
    acc_e = {acc_e[63:32] - p[63:32], acc_e[31:0] - p[31:0]};
    issue(4'h0, 3'h1, 3'h5, 5'h03, 5'h04, 1'b0, 1'b0, acc_e);
    // refused ops must leave both result and accumulator untouched;
    // reading the live destination exercises the write-back bypass
    for (int i = 0; i < 7; i++)
      issue(bad[i][9:6], bad[i][5:3], bad[i][2:0], 5'h1f, 5'h02, 1'b1, 1'b0,
            64'h0000_0000_0000_0000);
    @(negedge clk);
    issue_valid = 1'b0;
    load(5'h05, 64'h8000_0000_8000_0000);
    load(5'h06, 64'h0000_8000_0000_8000);
    issue(4'h4, 3'h3, 3'h0, 5'h05, 5'h05, 1'b0, 1'b1, 64'h7fff_ffff_7fff_ffff);
    issue(4'h0, 3'h3, 3'h0, 5'h06, 5'h06, 1'b0, 1'b1, 64'h7fff_ffff_7fff_ffff);
    @(negedge clk);
    issue_valid = 1'b0;
    repeat (4) @(negedge clk);
    cmp1(q.size() == 0, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
